// *** rtl/cod_core.sv ***
// Instruction sequencer: fetch, addressing, stack, vector and wait handling
module cod_core (
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              irq_req,
	input  wire logic [7:0]        bus_rdata,
	output logic      [15:0]       bus_addr,
	output logic      [7:0]        bus_wdata,
	output logic                   bus_rd,
	output logic                   bus_wr,
	output cod_pkg::cod_cyc_t      cycle_kind,
	output logic      [7:0]        condition_flags,
	output logic                   wait_halted,
	output logic                   irq_ack,
	output logic      [3:0]        instr_cycles
);
	cod_dec_if dif ();
	cod_decoder i_cod_decoder (.d(dif));

	cod_pkg::cod_state_t state_q;
	cod_pkg::cod_dec_t   info_q;
	logic [15:0] pc_q;
	logic [15:0] sp_q;
	logic [7:0]  a_q;
	logic [7:0]  h_q;
	logic [7:0]  x_q;
	logic [7:0]  ccr_q;
	logic [7:0]  b1_q;
	logic [7:0]  b2_q;
	logic [7:0]  tmp_q;
	logic [2:0]  bit_q;
	logic [2:0]  push_q;
	logic        vec_rst_q;
	logic [15:0] hx;
	logic [15:0] ea;
	logic        irq_take;
	logic        br_take;
	logic [15:0] rel_tgt;
	logic [7:0]  push_byte;

	assign hx       = {h_q, x_q};
	assign irq_take = (state_q == cod_pkg::COD_S_FETCH) && irq_req && !ccr_q[cod_pkg::COD_FLAG_I];
	assign dif.opcode   = bus_rdata;
	assign dif.prefixed = (state_q == cod_pkg::COD_S_PRE);

	function automatic logic [15:0] cod_zx(input logic [7:0] v);
		return {8'h00, v};
	endfunction

	function automatic cod_pkg::cod_state_t cod_dispatch(input cod_pkg::cod_dec_t i);
		case (i.op)
		cod_pkg::COD_OP_PRE:  return cod_pkg::COD_S_PRE;
		cod_pkg::COD_OP_TXS,
		cod_pkg::COD_OP_WAIT: return cod_pkg::COD_S_FREE;
		cod_pkg::COD_OP_BRA,
		cod_pkg::COD_OP_BRN:  return cod_pkg::COD_S_REL;
		cod_pkg::COD_OP_ILL:  return cod_pkg::COD_S_FETCH;
		default: begin
			if (i.nopr != 2'h0) return cod_pkg::COD_S_OP1;
			return (i.op == cod_pkg::COD_OP_STA) ? cod_pkg::COD_S_WR : cod_pkg::COD_S_RD;
		end
		endcase
	endfunction

	// Effective address from operand bytes; b1 is the high byte of two-byte operands
	always_comb begin
		case (info_q.mode)
		cod_pkg::COD_DIR:                         ea = cod_zx(b1_q);
		cod_pkg::COD_FULL_ADDRESS_MODE:           ea = {b1_q, b2_q};
		cod_pkg::COD_INDEXED_BYTE_OFFSET:         ea = hx + cod_zx(b1_q);
		cod_pkg::COD_INDEXED_WORD_OFFSET:         ea = hx + {b1_q, b2_q};
		cod_pkg::COD_INDEXED_BYTE_OFFSET_POSTINC: ea = hx + cod_zx(b1_q);
		cod_pkg::COD_STACK_BYTE_OFFSET:           ea = sp_q + cod_zx(b1_q);
		cod_pkg::COD_STACK_WORD_OFFSET:           ea = sp_q + {b1_q, b2_q};
		default:                                  ea = hx;
		endcase
	end

	// Offset counts from the byte after the rel byte itself
	assign rel_tgt = pc_q + 16'h0001 + {{8{bus_rdata[7]}}, bus_rdata};
	assign br_take = (info_q.op == cod_pkg::COD_OP_BRA)
		|| ((info_q.op == cod_pkg::COD_OP_CBEQ) && (a_q == tmp_q));

	always_comb begin
		case (push_q)
		3'h0:    push_byte = pc_q[7:0];
		3'h1:    push_byte = pc_q[15:8];
		3'h2:    push_byte = x_q;
		3'h3:    push_byte = a_q;
		default: push_byte = ccr_q;
		endcase
	end

	// Bus presentation; free cycles and the idle wait show as reads
	always_comb begin
		bus_addr   = pc_q;
		bus_wdata  = 8'h00;
		bus_rd     = 1'b1;
		bus_wr     = 1'b0;
		cycle_kind = cod_pkg::COD_CYC_PROG;
		case (state_q)
		cod_pkg::COD_S_RD: begin
			bus_addr   = ea;
			cycle_kind = cod_pkg::COD_CYC_READ;
		end
		cod_pkg::COD_S_WR: begin
			bus_addr   = ea;
			bus_rd     = 1'b0;
			bus_wr     = 1'b1;
			bus_wdata  = (info_q.op == cod_pkg::COD_OP_STA) ? a_q : tmp_q;
			cycle_kind = cod_pkg::COD_CYC_WRITE;
		end
		cod_pkg::COD_S_FREE: cycle_kind = cod_pkg::COD_CYC_FREE;
		cod_pkg::COD_S_WAIT: cycle_kind = cod_pkg::COD_CYC_IDLE;
		cod_pkg::COD_S_PUSH: begin
			bus_addr   = sp_q;
			bus_rd     = 1'b0;
			bus_wr     = 1'b1;
			bus_wdata  = push_byte;
			cycle_kind = cod_pkg::COD_CYC_PUSH;
		end
		cod_pkg::COD_S_VH: begin
			bus_addr   = vec_rst_q ? cod_pkg::COD_VEC_RESET : cod_pkg::COD_VEC_IRQ;
			cycle_kind = cod_pkg::COD_CYC_VEC;
		end
		cod_pkg::COD_S_VL: begin
			bus_addr   = (vec_rst_q ? cod_pkg::COD_VEC_RESET : cod_pkg::COD_VEC_IRQ) + 16'h0001;
			cycle_kind = cod_pkg::COD_CYC_VEC;
		end
		default: ;
		endcase
	end

	assign condition_flags = ccr_q;
	assign wait_halted     = (state_q == cod_pkg::COD_S_WAIT);
	assign irq_ack         = (state_q == cod_pkg::COD_S_VH) && !vec_rst_q;
	assign instr_cycles    = info_q.cycles;

	// Sequencing of bus cycle kinds
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_q <= cod_pkg::COD_S_VH;
		end else begin
			case (state_q)
			cod_pkg::COD_S_FETCH: state_q <= irq_take ? cod_pkg::COD_S_PUSH : cod_dispatch(dif.info);
			cod_pkg::COD_S_PRE:   state_q <= cod_dispatch(dif.info);
			cod_pkg::COD_S_OP1: begin
				if (info_q.nopr == 2'h2) state_q <= cod_pkg::COD_S_OP2;
				else if (info_q.mode == cod_pkg::COD_IMM) state_q <= cod_pkg::COD_S_FETCH;
				else if (info_q.op == cod_pkg::COD_OP_STA) state_q <= cod_pkg::COD_S_WR;
				else state_q <= cod_pkg::COD_S_RD;
			end
			cod_pkg::COD_S_OP2: state_q <= (info_q.op == cod_pkg::COD_OP_STA)
				? cod_pkg::COD_S_WR : cod_pkg::COD_S_RD;
			cod_pkg::COD_S_RD: begin
				case (info_q.op)
				cod_pkg::COD_OP_CBEQ: state_q <= cod_pkg::COD_S_REL;
				cod_pkg::COD_OP_LDA:  state_q <= cod_pkg::COD_S_FETCH;
				default:              state_q <= cod_pkg::COD_S_WR;
				endcase
			end
			cod_pkg::COD_S_FREE: state_q <= (info_q.op == cod_pkg::COD_OP_WAIT)
				? cod_pkg::COD_S_WAIT : cod_pkg::COD_S_FETCH;
			cod_pkg::COD_S_WAIT: state_q <= irq_req ? cod_pkg::COD_S_PUSH : cod_pkg::COD_S_WAIT;
			cod_pkg::COD_S_PUSH: state_q <= (push_q == cod_pkg::COD_PUSH_LAST)
				? cod_pkg::COD_S_VH : cod_pkg::COD_S_PUSH;
			cod_pkg::COD_S_VH:   state_q <= cod_pkg::COD_S_VL;
			default:             state_q <= cod_pkg::COD_S_FETCH;
			endcase
		end
	end

	// Decode capture and operand bytes
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			info_q <= '{cod_pkg::COD_OP_ILL, cod_pkg::COD_NO_OPERAND_MODE, 2'h0, 3'h1, 4'h1};
			b1_q   <= 8'h00;
			b2_q   <= 8'h00;
			bit_q  <= 3'h0;
		end else begin
			if ((state_q == cod_pkg::COD_S_FETCH && !irq_take) || state_q == cod_pkg::COD_S_PRE) begin
				info_q <= dif.info;
				bit_q  <= bus_rdata[3:1];
			end
			if (state_q == cod_pkg::COD_S_OP1) b1_q <= bus_rdata;
			if (state_q == cod_pkg::COD_S_OP2) b2_q <= bus_rdata;
		end
	end

	// Program counter
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pc_q <= 16'h0000;
		end else begin
			case (state_q)
			cod_pkg::COD_S_FETCH: if (!irq_take) pc_q <= pc_q + 16'h0001;
			cod_pkg::COD_S_PRE,
			cod_pkg::COD_S_OP1,
			cod_pkg::COD_S_OP2:   pc_q <= pc_q + 16'h0001;
			cod_pkg::COD_S_REL:   pc_q <= br_take ? rel_tgt : pc_q + 16'h0001;
			cod_pkg::COD_S_VH:    pc_q[15:8] <= bus_rdata;
			cod_pkg::COD_S_VL:    pc_q[7:0] <= bus_rdata;
			default: ;
			endcase
		end
	end

	// Stack pointer and push counter
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sp_q      <= cod_pkg::COD_SP_RST;
			push_q    <= 3'h0;
			vec_rst_q <= 1'b1;
		end else begin
			if (state_q == cod_pkg::COD_S_FREE && info_q.op == cod_pkg::COD_OP_TXS)
				sp_q <= hx - 16'h0001;
			if (state_q == cod_pkg::COD_S_PUSH) begin
				sp_q   <= sp_q - 16'h0001;
				push_q <= push_q + 3'h1;
			end else begin
				push_q <= 3'h0;
			end
			if (state_q == cod_pkg::COD_S_VL) vec_rst_q <= 1'b0;
		end
	end

	// Accumulator, index pair, flags, read-modify-write byte
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			a_q   <= 8'h00;
			h_q   <= 8'h00;
			x_q   <= 8'h00;
			ccr_q <= cod_pkg::COD_FLAGS_RST;
			tmp_q <= 8'h00;
		end else begin
			if ((state_q == cod_pkg::COD_S_OP1 && info_q.mode == cod_pkg::COD_IMM)
				|| (state_q == cod_pkg::COD_S_RD && info_q.op == cod_pkg::COD_OP_LDA)) begin
				a_q <= bus_rdata;
				ccr_q[cod_pkg::COD_FLAG_N] <= bus_rdata[7];
				ccr_q[cod_pkg::COD_FLAG_Z] <= (bus_rdata == 8'h00);
			end
			if (state_q == cod_pkg::COD_S_RD) begin
				case (info_q.op)
				cod_pkg::COD_OP_BSET: tmp_q <= bus_rdata | (8'h01 << bit_q);
				cod_pkg::COD_OP_BCLR: tmp_q <= bus_rdata & ~(8'h01 << bit_q);
				cod_pkg::COD_OP_CBEQ: begin
					tmp_q      <= bus_rdata;
					{h_q, x_q} <= hx + 16'h0001;
				end
				default: ;
				endcase
			end
			if (state_q == cod_pkg::COD_S_FREE && info_q.op == cod_pkg::COD_OP_WAIT)
				ccr_q[cod_pkg::COD_FLAG_I] <= 1'b0;
			if (state_q == cod_pkg::COD_S_VH) ccr_q[cod_pkg::COD_FLAG_I] <= 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_txs_sp_load: assert property ((state_q == cod_pkg::COD_S_FREE && info_q.op == cod_pkg::COD_OP_TXS)
		|=> sp_q == $past(hx) - 16'h0001) else $error("stack pointer not index minus one");
	a_wait_mask_clr: assert property ((state_q == cod_pkg::COD_S_FREE && info_q.op == cod_pkg::COD_OP_WAIT)
		|=> !ccr_q[cod_pkg::COD_FLAG_I] && state_q == cod_pkg::COD_S_WAIT) else $error("wait entry wrong");
	a_wait_holds: assert property ((state_q == cod_pkg::COD_S_WAIT && !irq_req)
		|=> state_q == cod_pkg::COD_S_WAIT) else $error("wait left without interrupt");
	a_free_one_read: assert property ((state_q == cod_pkg::COD_S_FREE)
		|-> bus_rd && !bus_wr ##1 state_q != cod_pkg::COD_S_FREE) else $error("free cycle wrong");
	a_fetch_advance: assert property ((state_q == cod_pkg::COD_S_FETCH && !irq_take)
		|-> bus_addr == pc_q ##1 pc_q == $past(pc_q) + 16'h0001) else $error("fetch did not advance");
	a_vector_order: assert property ((state_q == cod_pkg::COD_S_VH)
		|-> bus_addr[15:8] == cod_pkg::COD_TOP_PAGE
		##1 state_q == cod_pkg::COD_S_VL && bus_addr == $past(bus_addr) + 16'h0001)
		else $error("vector read order wrong");
	a_push_dec: assert property ((state_q == cod_pkg::COD_S_PUSH)
		|-> bus_wr && bus_addr == sp_q ##1 sp_q == $past(sp_q) - 16'h0001) else $error("push wrong");
	a_branch_target: assert property ((state_q == cod_pkg::COD_S_REL && info_q.op == cod_pkg::COD_OP_BRA)
		|=> pc_q == $past(pc_q) + 16'h0001 + {{8{$past(bus_rdata[7])}}, $past(bus_rdata)})
		else $error("branch target wrong");
	a_direct_page: assert property ((state_q == cod_pkg::COD_S_RD && info_q.mode == cod_pkg::COD_DIR)
		|-> bus_addr[15:8] == 8'h00) else $error("direct address not in page zero");
	a_postinc_index: assert property ((state_q == cod_pkg::COD_S_RD && info_q.op == cod_pkg::COD_OP_CBEQ)
		|-> bus_addr == ea ##1 hx == $past(hx) + 16'h0001) else $error("post increment wrong");

	c_txs_run:   cover property (state_q == cod_pkg::COD_S_FREE && info_q.op == cod_pkg::COD_OP_TXS);
	c_wait_wake: cover property (state_q == cod_pkg::COD_S_WAIT ##1 state_q == cod_pkg::COD_S_PUSH);
	c_bset_wr:   cover property (state_q == cod_pkg::COD_S_WR && info_q.op == cod_pkg::COD_OP_BSET);
	c_sp2_read:  cover property (state_q == cod_pkg::COD_S_RD
		&& info_q.mode == cod_pkg::COD_STACK_WORD_OFFSET);
endmodule

// *** rtl/cod_pkg.sv ***
// Shared types and constants of the opcode decode and bus-cycle sequencer
// What this block does
// - Opcode 94 loads the stack pointer with index pair minus one in two cycles.
// - Opcode 8F clears the interrupt mask and halts until an interrupt arrives.
// - A free cycle lasts one clock, uses no bus, and shows as a read.
// - Program fetch reads the next instruction byte and advances the program counter.
// - Vector read fetches from the top page, high byte before low byte.
// - Push writes one byte at the stack pointer then decrements it.
// - Branch target is next instruction address plus a signed byte offset.
// - Direct mode uses one operand byte as low address, high half zero.
// - Extended mode takes a full 16-bit address from two operand bytes.
// - Byte-offset indexed mode adds a zero-extended byte to the index pair.
// - Word-offset indexed mode adds a 16-bit offset to the index pair.
// - Post-increment mode reads at the index pair, then increments it.
// - Byte-offset post-increment reads at index plus offset, then increments index.
// - Stack-relative modes add an 8-bit or 16-bit offset to the stack pointer.
// - Bit instructions pick bit 0 to 7 with a 3-bit opcode field.
package cod_pkg;
	typedef enum logic [3:0] {
		COD_OP_ILL, COD_OP_PRE, COD_OP_TXS, COD_OP_WAIT, COD_OP_BRA, COD_OP_BRN,
		COD_OP_LDA, COD_OP_STA, COD_OP_BSET, COD_OP_BCLR, COD_OP_CBEQ
	} cod_op_t;
	typedef enum logic [3:0] {
		COD_NO_OPERAND_MODE, COD_IMM, COD_DIR, COD_FULL_ADDRESS_MODE, COD_IX,
		COD_INDEXED_BYTE_OFFSET, COD_INDEXED_WORD_OFFSET, COD_INDEXED_POSTINC,
		COD_INDEXED_BYTE_OFFSET_POSTINC, COD_STACK_BYTE_OFFSET, COD_STACK_WORD_OFFSET,
		COD_REL
	} cod_mode_t;
	typedef struct packed {
		cod_op_t   op;
		cod_mode_t mode;
		logic [1:0] nopr;
		logic [2:0] len;
		logic [3:0] cycles;
	} cod_dec_t;
	typedef enum logic [2:0] {
		COD_CYC_PROG, COD_CYC_READ, COD_CYC_WRITE, COD_CYC_FREE,
		COD_CYC_PUSH, COD_CYC_VEC, COD_CYC_IDLE
	} cod_cyc_t;
	typedef enum logic [3:0] {
		COD_S_FETCH, COD_S_PRE, COD_S_OP1, COD_S_OP2, COD_S_RD, COD_S_WR, COD_S_REL,
		COD_S_FREE, COD_S_PUSH, COD_S_VH, COD_S_VL, COD_S_WAIT
	} cod_state_t;
	localparam logic [7:0]  COD_OPC_PREFIX  = 8'h9E;
	localparam logic [7:0]  COD_FLAGS_RST   = 8'h68;
	localparam int          COD_FLAG_I      = 3;
	localparam int          COD_FLAG_N      = 2;
	localparam int          COD_FLAG_Z      = 1;
	localparam logic [15:0] COD_SP_RST      = 16'h00FF;
	localparam logic [15:0] COD_VEC_RESET   = 16'hFFFE;
	localparam logic [15:0] COD_VEC_IRQ     = 16'hFFFA;
	localparam logic [7:0]  COD_TOP_PAGE    = 8'hFF;
	localparam logic [2:0]  COD_PUSH_LAST   = 3'h4;
endpackage

// *** rtl/cod_dec_if.sv ***
// Carrier between the sequencer and its opcode decoder
interface cod_dec_if;
	logic             [7:0] opcode;
	logic                   prefixed;
	cod_pkg::cod_dec_t      info;
	modport dec (input opcode, input prefixed, output info);
	modport seq (output opcode, output prefixed, input info);
endinterface

// *** rtl/cod_decoder.sv ***
// Opcode to operation, addressing mode, length and cycle count
module cod_decoder (
	cod_dec_if.dec d
);
	always_comb begin
		d.info = '{cod_pkg::COD_OP_ILL, cod_pkg::COD_NO_OPERAND_MODE, 2'h0, 3'h1, 4'h1};
		if (d.prefixed) begin
			case (d.opcode)
			8'hE6: d.info = '{cod_pkg::COD_OP_LDA, cod_pkg::COD_STACK_BYTE_OFFSET, 2'h1, 3'h3, 4'h4};
			8'hD6: d.info = '{cod_pkg::COD_OP_LDA, cod_pkg::COD_STACK_WORD_OFFSET, 2'h2, 3'h4, 4'h5};
			8'hE7: d.info = '{cod_pkg::COD_OP_STA, cod_pkg::COD_STACK_BYTE_OFFSET, 2'h1, 3'h3, 4'h4};
			8'hD7: d.info = '{cod_pkg::COD_OP_STA, cod_pkg::COD_STACK_WORD_OFFSET, 2'h2, 3'h4, 4'h5};
			default: ;
			endcase
		end else begin
			case (d.opcode)
			8'h9E: d.info = '{cod_pkg::COD_OP_PRE, cod_pkg::COD_NO_OPERAND_MODE, 2'h0, 3'h1, 4'h1};
			8'h94: d.info = '{cod_pkg::COD_OP_TXS, cod_pkg::COD_NO_OPERAND_MODE, 2'h0, 3'h1, 4'h2};
			8'h8F: d.info = '{cod_pkg::COD_OP_WAIT, cod_pkg::COD_NO_OPERAND_MODE, 2'h0, 3'h1, 4'h2};
			8'h20: d.info = '{cod_pkg::COD_OP_BRA, cod_pkg::COD_REL, 2'h0, 3'h2, 4'h3};
			8'h21: d.info = '{cod_pkg::COD_OP_BRN, cod_pkg::COD_REL, 2'h0, 3'h2, 4'h3};
			8'hA6: d.info = '{cod_pkg::COD_OP_LDA, cod_pkg::COD_IMM, 2'h1, 3'h2, 4'h2};
			8'hB6: d.info = '{cod_pkg::COD_OP_LDA, cod_pkg::COD_DIR, 2'h1, 3'h2, 4'h3};
			8'hC6: d.info = '{cod_pkg::COD_OP_LDA, cod_pkg::COD_FULL_ADDRESS_MODE, 2'h2, 3'h3, 4'h4};
			8'hD6: d.info = '{cod_pkg::COD_OP_LDA, cod_pkg::COD_INDEXED_WORD_OFFSET, 2'h2, 3'h3, 4'h4};
			8'hE6: d.info = '{cod_pkg::COD_OP_LDA, cod_pkg::COD_INDEXED_BYTE_OFFSET, 2'h1, 3'h2, 4'h3};
			8'hF6: d.info = '{cod_pkg::COD_OP_LDA, cod_pkg::COD_IX, 2'h0, 3'h1, 4'h3};
			8'hB7: d.info = '{cod_pkg::COD_OP_STA, cod_pkg::COD_DIR, 2'h1, 3'h2, 4'h3};
			8'hC7: d.info = '{cod_pkg::COD_OP_STA, cod_pkg::COD_FULL_ADDRESS_MODE, 2'h2, 3'h3, 4'h4};
			8'hD7: d.info = '{cod_pkg::COD_OP_STA, cod_pkg::COD_INDEXED_WORD_OFFSET, 2'h2, 3'h3, 4'h4};
			8'hE7: d.info = '{cod_pkg::COD_OP_STA, cod_pkg::COD_INDEXED_BYTE_OFFSET, 2'h1, 3'h2, 4'h3};
			8'hF7: d.info = '{cod_pkg::COD_OP_STA, cod_pkg::COD_IX, 2'h0, 3'h1, 4'h2};
			8'h71: d.info = '{cod_pkg::COD_OP_CBEQ, cod_pkg::COD_INDEXED_POSTINC, 2'h0, 3'h2, 4'h5};
			8'h61: d.info = '{cod_pkg::COD_OP_CBEQ, cod_pkg::COD_INDEXED_BYTE_OFFSET_POSTINC,
				2'h1, 3'h3, 4'h5};
			default: begin
				if (d.opcode[7:4] == 4'h1) begin
					d.info = '{d.opcode[0] ? cod_pkg::COD_OP_BCLR : cod_pkg::COD_OP_BSET,
						cod_pkg::COD_DIR, 2'h1, 3'h2, 4'h5};
				end
			end
			endcase
		end
	end
endmodule

// *** tb/cod_mem_model.sv ***
// Zero-wait system memory seen by the core's bus
module cod_mem_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_rd,
	input  wire logic        bus_wr,
	output logic      [7:0]  bus_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [0:65535];
	logic [7:0] last_q;

	// Outside a read the data lines carry the inverse of the last value, so no stale byte helps
	assign bus_rdata = bus_rd ? mem[bus_addr] : ~last_q;

	always @(posedge sys_clk) begin
		if (bus_rd) begin
			last_q <= mem[bus_addr];
		end
		if (bus_wr) begin
			mem[bus_addr] <= bus_wdata;
		end
	end

	initial begin
		last_q = 8'h00;
	end
endmodule

// *** tb/cpu_opcode_decode_tail_tb.sv ***
// Self-checking bench: runs a short program and compares every bus cycle
module cpu_opcode_decode_tail_tb;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		cod_pkg::cod_cyc_t kind;
		logic [15:0]       addr;
		logic              wr;
		logic [7:0]        wd;
		logic              ack;
		logic [3:0]        cyc;
	} cod_exp_t;

	logic              sys_clk;
	logic              nrst;
	logic              irq_req;
	logic [7:0]        bus_rdata;
	logic [15:0]       bus_addr;
	logic [7:0]        bus_wdata;
	logic              bus_rd;
	logic              bus_wr;
	cod_pkg::cod_cyc_t cycle_kind;
	logic [7:0]        condition_flags;
	logic              wait_halted;
	logic              irq_ack;
	logic [3:0]        instr_cycles;
	cod_exp_t          exp_q[$];
	cod_exp_t          e;
	int                error_cnt;
	int                compares;
	logic [7:0]        r;
	logic [7:0]        flags_exp;
	logic [7:0]        prog_a[0:6];
	logic [7:0]        prog_b[0:5];
	logic [7:0]        prog_c[0:14];

	cod_core i_cod_core (
		.sys_clk         (sys_clk),
		.nrst            (nrst),
		.irq_req         (irq_req),
		.bus_rdata       (bus_rdata),
		.bus_addr        (bus_addr),
		.bus_wdata       (bus_wdata),
		.bus_rd          (bus_rd),
		.bus_wr          (bus_wr),
		.cycle_kind      (cycle_kind),
		.condition_flags (condition_flags),
		.wait_halted     (wait_halted),
		.irq_ack         (irq_ack),
		.instr_cycles    (instr_cycles)
	);

	cod_mem_model i_cod_mem_model (
		.sys_clk   (sys_clk),
		.bus_addr  (bus_addr),
		.bus_wdata (bus_wdata),
		.bus_rd    (bus_rd),
		.bus_wr    (bus_wr),
		.bus_rdata (bus_rdata)
	);

	always #2.5 sys_clk = ~sys_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic ex(input cod_pkg::cod_cyc_t k, input logic [15:0] a, input logic [7:0] d);
		cod_exp_t n;
		n.kind = k;
		n.addr = a;
		n.wr = (k == cod_pkg::COD_CYC_WRITE) || (k == cod_pkg::COD_CYC_PUSH);
		n.wd = d;
		n.ack = (k == cod_pkg::COD_CYC_VEC) && (a == 16'hFFFA);
		n.cyc = 4'h0;
		exp_q.push_back(n);
	endtask

	// Attaches a documented cycle count to the newest expected cycle
	task automatic exc(input logic [3:0] c);
		exp_q[$].cyc = c;
	endtask

	task automatic put(input logic [15:0] a, input logic [7:0] d);
		i_cod_mem_model.mem[a] = d;
	endtask

	// Sample 1 ns after the falling edge so every update of the rising edge has landed
	initial begin
		forever begin
			@(negedge sys_clk);
			#1;
			if (nrst === 1'b1 && exp_q.size() > 0) begin
				if (cycle_kind === cod_pkg::COD_CYC_IDLE) begin
					check(16'(wait_halted), 16'h0001);
					check(16'(condition_flags[cod_pkg::COD_FLAG_I]), 16'h0000);
				end else begin
					e = exp_q.pop_front();
					check(16'(cycle_kind), 16'(e.kind));
					if (e.kind != cod_pkg::COD_CYC_FREE) check(bus_addr, e.addr);
					check(16'(bus_wr), 16'(e.wr));
					check(16'(bus_rd), 16'(!e.wr));
					if (e.wr) check(16'(bus_wdata), 16'(e.wd));
					check(16'(irq_ack), 16'(e.ack));
					if (e.cyc != 4'h0) check(16'(instr_cycles), 16'(e.cyc));
				end
			end
		end
	end

	// Interrupt source: raises the request only once the core has halted
	initial begin
		irq_req = 1'b0;
		@(posedge nrst);
		for (int i = 0; i < 400 && wait_halted !== 1'b1; i++) @(negedge sys_clk);
		repeat (3) @(negedge sys_clk);
		irq_req = 1'b1;
		for (int i = 0; i < 40 && irq_ack !== 1'b1; i++) @(negedge sys_clk);
		@(negedge sys_clk);
		irq_req = 1'b0;
		#1;
		check(16'(condition_flags[cod_pkg::COD_FLAG_I]), 16'h0001);
	end

	initial begin
		#(5ns * 3000);
		error_cnt++;
		$display("watchdog expired");
		wrap_up();
	end

	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		error_cnt = 0;
		compares = 0;
		void'($urandom(31));
		r = 8'($urandom()) | 8'h01;
		flags_exp = 8'h60 | (r[7] ? 8'h04 : 8'h00);
		for (int i = 0; i < 65536; i++) put(16'(i), 8'h9D);
		put(16'hFFFE, 8'h01);
		put(16'hFFFF, 8'h00);
		put(16'hFFFA, 8'h02);
		put(16'hFFFB, 8'h00);
		put(16'h1234, r);
		put(16'h0000, r);
		put(16'h0011, ~r);
		// Full address load, direct store, compare with post-increment and a -128 branch
		prog_a = '{8'hC6, 8'h12, 8'h34, 8'hB7, 8'hC3, 8'h71, 8'h80};
		foreach (prog_a[i]) put(16'h0100 + 16'(i), prog_a[i]);
		// Index to stack, stack-offset store, +127 branch onto the wait
		prog_b = '{8'h94, 8'h9E, 8'hE7, 8'h05, 8'h20, 8'h7F};
		foreach (prog_b[i]) put(16'h0087 + 16'(i), prog_b[i]);
		put(16'h010C, 8'h8F);
		// Handler: bit set and clear, indexed loads, compare not taken, then a tight loop
		prog_c = '{8'h16, 8'hC3, 8'h11, 8'hC3, 8'hE6, 8'h10, 8'hD6, 8'h12, 8'h33,
			8'h61, 8'h10, 8'h02, 8'hF6, 8'h20, 8'hFE};
		foreach (prog_c[i]) put(16'h0200 + 16'(i), prog_c[i]);
		ex(cod_pkg::COD_CYC_VEC, 16'hFFFE, 8'h00);
		ex(cod_pkg::COD_CYC_VEC, 16'hFFFF, 8'h00);
		for (int i = 0; i < 3; i++) ex(cod_pkg::COD_CYC_PROG, 16'h0100 + 16'(i), 8'h00);
		ex(cod_pkg::COD_CYC_READ, 16'h1234, 8'h00);
		exc(4'h4);
		ex(cod_pkg::COD_CYC_PROG, 16'h0103, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h0104, 8'h00);
		ex(cod_pkg::COD_CYC_WRITE, 16'h00C3, r);
		exc(4'h3);
		ex(cod_pkg::COD_CYC_PROG, 16'h0105, 8'h00);
		ex(cod_pkg::COD_CYC_READ, 16'h0000, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h0106, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h0087, 8'h00);
		ex(cod_pkg::COD_CYC_FREE, 16'h0000, 8'h00);
		exc(4'h2);
		for (int i = 0; i < 3; i++) ex(cod_pkg::COD_CYC_PROG, 16'h0088 + 16'(i), 8'h00);
		ex(cod_pkg::COD_CYC_WRITE, 16'h0005, r);
		ex(cod_pkg::COD_CYC_PROG, 16'h008B, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h008C, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h010C, 8'h00);
		ex(cod_pkg::COD_CYC_FREE, 16'h0000, 8'h00);
		exc(4'h2);
		ex(cod_pkg::COD_CYC_PUSH, 16'h0000, 8'h0D);
		ex(cod_pkg::COD_CYC_PUSH, 16'hFFFF, 8'h01);
		ex(cod_pkg::COD_CYC_PUSH, 16'hFFFE, 8'h01);
		ex(cod_pkg::COD_CYC_PUSH, 16'hFFFD, r);
		ex(cod_pkg::COD_CYC_PUSH, 16'hFFFC, flags_exp);
		ex(cod_pkg::COD_CYC_VEC, 16'hFFFA, 8'h00);
		ex(cod_pkg::COD_CYC_VEC, 16'hFFFB, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h0200, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h0201, 8'h00);
		ex(cod_pkg::COD_CYC_READ, 16'h00C3, 8'h00);
		ex(cod_pkg::COD_CYC_WRITE, 16'h00C3, r | 8'h08);
		exc(4'h5);
		ex(cod_pkg::COD_CYC_PROG, 16'h0202, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h0203, 8'h00);
		ex(cod_pkg::COD_CYC_READ, 16'h00C3, 8'h00);
		ex(cod_pkg::COD_CYC_WRITE, 16'h00C3, (r | 8'h08) & 8'hFE);
		ex(cod_pkg::COD_CYC_PROG, 16'h0204, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h0205, 8'h00);
		ex(cod_pkg::COD_CYC_READ, 16'h0011, 8'h00);
		for (int i = 0; i < 3; i++) ex(cod_pkg::COD_CYC_PROG, 16'h0206 + 16'(i), 8'h00);
		ex(cod_pkg::COD_CYC_READ, 16'h1234, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h0209, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h020A, 8'h00);
		ex(cod_pkg::COD_CYC_READ, 16'h0011, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h020B, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h020C, 8'h00);
		ex(cod_pkg::COD_CYC_READ, 16'h0002, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h020D, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h020E, 8'h00);
		ex(cod_pkg::COD_CYC_PROG, 16'h020D, 8'h00);
		repeat (8) @(negedge sys_clk);
		nrst = 1'b1;
		for (int i = 0; i < 600 && exp_q.size() > 0; i++) @(negedge sys_clk);
		check(16'(exp_q.size()), 16'h0000);
		repeat (2) @(negedge sys_clk);
		$display("program trace test done");
		wrap_up();
	end
endmodule
